// ===== common/linefeed_pkg.sv
// Functional notes
// (RULE_01) Start bit launches calibration and clears itself when the cycle ends.
// (RULE_02) Reset leaves the line open; calibration may start from there.
// (RULE_03) Selected calibrations run MSB to LSB, primary register then secondary.
// (RULE_04) Writing primary bit 7 starts the whole calibration sequence.
// (RULE_05) Host writes secondary selections before writing the primary register.
// (RULE_06) Host always writes zero to primary reserved bit 6.
// (RULE_07) Calibration failure, including off-hook during balance, sets status bit 7.
// (RULE_08) Calibration engine owns tip and ring drive while any step runs.
// (RULE_09) Host starts leakage calibrations only on-hook, writing the fixed value.
// (RULE_10) Leakage calibration lasts about 5 ms and disturbs feed and voice.
// (RULE_11) Host loads the two impedance coefficients before balance calibration.
// (RULE_12) Host enables balance interrupt, then selects only the balance routine.
// (RULE_13) Primary register reads zero when balance calibration ends, within 100 ms.
// (RULE_14) Host checks the balance error flag, retries, restores registers.
// (RULE_15) Host calibrates only on-hook and never grounds tip or ring.
// (RULE_16) 8-bit samples refresh monitor values at 800 Hz with loop voltage and current.
// (RULE_17) Ground start reports ring voltage and ring current instead.
// (RULE_18) Excess power forces the open state and raises a power alarm.
// (RULE_19) Discrete mode estimates six transistor powers, 0.75 V offset on first two.
// (RULE_20) Transistor alarm bit sets on comparator rising edge, held until cleared.
// (RULE_21) Each transistor alarm is maskable by its enable bit.
// (RULE_22) Integrated mode sums six powers, 0.75 V offset on first four terms.
// (RULE_23) Filtered total power above threshold issues a power alarm.
// (RULE_24) After an alarm the line stays open until software changes state.
// (RULE_25) Each channel keeps its own sequencer, monitor values and alarm state.
package linefeed_pkg;
   localparam logic [7:0] ADDR_COEF_A     = 8'h21;
   localparam logic [7:0] ADDR_COEF_B     = 8'h22;
   localparam logic [7:0] ADDR_CAL_PRI    = 8'h1a;
   localparam logic [7:0] ADDR_CAL_SEC    = 8'h1b;
   localparam logic [7:0] ADDR_IRQ_ST3    = 8'h1c;
   localparam logic [7:0] ADDR_IRQ_EN3    = 8'h1d;
   localparam logic [7:0] ADDR_LINE_STATE = 8'h1e;
   localparam logic [7:0] ADDR_LOOP_V     = 8'h20;
   localparam logic [7:0] ADDR_LOOP_I     = 8'h23;
   localparam logic [7:0] ADDR_TOTAL_POWER_VALUE_LO    = 8'h24;
   localparam logic [7:0] ADDR_TOTAL_POWER_VALUE_HI    = 8'h25;
   localparam logic [7:0] ADDR_PTH_LO     = 8'h26;
   localparam logic [7:0] ADDR_PTH_HI     = 8'h27;
   localparam int         CAL_START_BIT   = 7;
   localparam int         CAL_RSVD_BIT    = 6;
   localparam int         CAL_ERR_BIT     = 7;
   localparam int         LEAK_LO_BIT     = 4;
   localparam int         LEAK_HI_BIT     = 5;
   localparam int         BAL_SEC_BIT     = 0;
   localparam logic [7:0] RESET_BYTE      = 8'h00;
   localparam logic [2:0] STATE_OPEN      = 3'h0;
   localparam int         CLK_MHZ         = 100;
   localparam int         LEAK_TIME_MS    = 5;
   localparam int         LEAK_CYCLES     = LEAK_TIME_MS * CLK_MHZ * 1000;
   localparam int         STEP_TIME_US    = 100;
   localparam int         STEP_CYCLES     = STEP_TIME_US * CLK_MHZ;
   localparam int         SAMPLE_HZ       = 800;
   localparam int         SAMPLE_CYCLES   = CLK_MHZ * 1000000 / SAMPLE_HZ;
   localparam logic [7:0] OFFSET_075      = 8'h03;
   localparam logic [15:0] PTH_RESET      = 16'hffff;
   localparam logic [7:0] DEFAULT_FILTER_SHIFT = 8'h03;
endpackage : linefeed_pkg

// ===== rtl/power_estimator.sv
`timescale 1ns/10ps
module power_estimator #(
   parameter int W = 8
) (
   input  wire logic [W-1:0]   tip_v_in,
   input  wire logic [W-1:0]   ring_v_in,
   input  wire logic [W-1:0]   bat_v_in,
   input  wire logic [6*W-1:0] q_i_in,
   input  wire logic [W-1:0]   drop_r7_in,
   input  wire logic [W-1:0]   drop_r6_in,
   input  wire logic           integrated_in,
   output logic [6*2*W-1:0]    q_pow_out,
   output logic [2*W+2:0]      total_pow_out
);
   function automatic logic [2*W-1:0] mul(input logic [W-1:0] v, input logic [W-1:0] i);
      mul = (2*W)'(v) * (2*W)'(i);
   endfunction : mul
   function automatic logic [W-1:0] sat_sub(input logic [W-1:0] a, input logic [W-1:0] b);
      sat_sub = (a > b) ? W'(a - b) : '0;
   endfunction : sat_sub
   function automatic logic [W-1:0] sat_add(input logic [W-1:0] a, input logic [W-1:0] b);
      sat_add = ((W+1)'(a) + (W+1)'(b) > (W+1)'({W{1'b1}})) ? {W{1'b1}} : W'(a + b);
   endfunction : sat_add
   wire logic [W-1:0] off = W'(linefeed_pkg::OFFSET_075);
   wire logic [W-1:0] vce [6];
   // Offset on first two in discrete mode, first four in integrated mode
   assign vce[0] = sat_add(tip_v_in, off); // RULE_19
   assign vce[1] = sat_add(ring_v_in, off); // RULE_19
   assign vce[2] = integrated_in ? sat_add(bat_v_in, off) : sat_sub(bat_v_in, drop_r7_in); // RULE_22
   assign vce[3] = integrated_in ? sat_add(bat_v_in, off) : sat_sub(bat_v_in, drop_r6_in); // RULE_22
   assign vce[4] = integrated_in ? sat_sub(bat_v_in, ring_v_in)
                                 : sat_sub(sat_sub(bat_v_in, ring_v_in), drop_r7_in);
   assign vce[5] = integrated_in ? sat_sub(bat_v_in, tip_v_in)
                                 : sat_sub(sat_sub(bat_v_in, tip_v_in), drop_r6_in);
   always_comb begin
      total_pow_out = '0;
      for (int k = 0; k < 6; k++) begin
         q_pow_out[k*2*W +: 2*W] = mul(vce[k], q_i_in[k*W +: W]);
         total_pow_out = total_pow_out + (2*W+3)'(mul(vce[k], q_i_in[k*W +: W])); // RULE_22
      end
   end
endmodule : power_estimator

// ===== rtl/linefeed_channel.sv
`timescale 1ns/10ps
module linefeed_channel #(
   parameter int W             = 8,
   parameter int LEAK_CYCLES   = linefeed_pkg::LEAK_CYCLES,
   parameter int STEP_CYCLES   = linefeed_pkg::STEP_CYCLES,
   parameter int SAMPLE_CYCLES = linefeed_pkg::SAMPLE_CYCLES
) (
   input  wire logic           core_clk_in,
   input  wire logic           rst_n_in,
   input  wire logic           clk_en_in,
   input  wire logic           reg_wr_in,
   input  wire logic           reg_rd_in,
   input  wire logic [7:0]     reg_addr_in,
   input  wire logic [7:0]     reg_wdata_in,
   output logic [7:0]          reg_rdata_out,
   input  wire logic [W-1:0]   tip_voltage_in,
   input  wire logic [W-1:0]   ring_voltage_in,
   input  wire logic [W-1:0]   bat_voltage_in,
   input  wire logic [W-1:0]   tip_current_in,
   input  wire logic [W-1:0]   ring_current_in,
   input  wire logic [6*W-1:0] q_current_in,
   input  wire logic [W-1:0]   drop_r7_in,
   input  wire logic [W-1:0]   drop_r6_in,
   input  wire logic           ground_start_in,
   input  wire logic           linefeed_presence_pin_in,
   input  wire logic           off_hook_in,
   input  wire logic           cal_step_fail_in,
   output logic                cal_drive_out,
   output logic [7:0]          cal_step_out,
   output logic                leak_busy_out,
   output logic [2:0]          line_state_out
);
   // One instance per channel; nothing is shared between instances RULE_25
   typedef enum logic [1:0] {CAL_IDLE, CAL_PICK, CAL_RUN} cal_state_t;
   localparam int LEAK_W = $clog2(LEAK_CYCLES + 1);
   localparam int SAMP_W = $clog2(SAMPLE_CYCLES + 1);
   localparam int PW     = 2*W + 3;

   cal_state_t         cal_state;
   logic [7:0]         cal_primary;
   logic [7:0]         cal_secondary;
   logic [15:0]        pending;
   logic [3:0]         cur_idx;
   logic [LEAK_W-1:0]  step_cnt;
   logic [7:0]         coef_a;
   logic [7:0]         coef_b;
   logic [7:0]         irq_status;
   logic [7:0]         irq_enable;
   logic [2:0]         line_state;
   logic [SAMP_W-1:0]  samp_cnt;
   logic [W-1:0]       loop_v;
   logic [W-1:0]       loop_i;
   logic [5:0]         cmp_prev;
   logic [PW-1:0]      filt_pow;
   logic               total_prev;
   logic [15:0]        pth;
   logic [6*2*W-1:0]   q_pow;
   logic [PW-1:0]      total_pow;
   logic [15:0]        total_power_value;

   function automatic logic [3:0] top_bit(input logic [15:0] v);
      top_bit = 4'h0;
      for (int k = 0; k < 16; k++) begin
         if (v[k]) top_bit = 4'(k);
      end
   endfunction : top_bit

   power_estimator #(.W(W)) u_est (
      .tip_v_in      (tip_voltage_in),
      .ring_v_in     (ring_voltage_in),
      .bat_v_in      (bat_voltage_in),
      .q_i_in        (q_current_in),
      .drop_r7_in    (drop_r7_in),
      .drop_r6_in    (drop_r6_in),
      .integrated_in (linefeed_presence_pin_in),
      .q_pow_out     (q_pow),
      .total_pow_out (total_pow)
   );

   wire logic wr_pri   = reg_wr_in && reg_addr_in == linefeed_pkg::ADDR_CAL_PRI;
   wire logic wr_sec   = reg_wr_in && reg_addr_in == linefeed_pkg::ADDR_CAL_SEC;
   wire logic wr_st3   = reg_wr_in && reg_addr_in == linefeed_pkg::ADDR_IRQ_ST3;
   wire logic wr_en3   = reg_wr_in && reg_addr_in == linefeed_pkg::ADDR_IRQ_EN3;
   wire logic wr_state = reg_wr_in && reg_addr_in == linefeed_pkg::ADDR_LINE_STATE;
   wire logic wr_ca    = reg_wr_in && reg_addr_in == linefeed_pkg::ADDR_COEF_A;
   wire logic wr_cb    = reg_wr_in && reg_addr_in == linefeed_pkg::ADDR_COEF_B;
   wire logic wr_pl    = reg_wr_in && reg_addr_in == linefeed_pkg::ADDR_PTH_LO;
   wire logic wr_ph    = reg_wr_in && reg_addr_in == linefeed_pkg::ADDR_PTH_HI;

   // Start only from idle; a write while busy is ignored to keep the sequence coherent
   wire logic start = wr_pri && reg_wdata_in[linefeed_pkg::CAL_START_BIT]
                      && cal_state == CAL_IDLE; // RULE_04
   // Index 15..8 map to primary bits 7..0, 7..0 to secondary; top index runs first
   wire logic [15:0] select_vec = {reg_wdata_in[7:0] & 8'h3f, cal_secondary}; // RULE_03
   wire logic is_leak = cur_idx == 4'(8 + linefeed_pkg::LEAK_LO_BIT)
                        || cur_idx == 4'(8 + linefeed_pkg::LEAK_HI_BIT);
   wire logic is_bal  = cur_idx == 4'(linefeed_pkg::BAL_SEC_BIT);
   wire logic [LEAK_W-1:0] step_len = is_leak ? LEAK_W'(LEAK_CYCLES - 1)
                                              : LEAK_W'(STEP_CYCLES - 1); // RULE_10
   wire logic step_done = cal_state == CAL_RUN && step_cnt == step_len;
   wire logic step_err  = cal_state == CAL_RUN && (cal_step_fail_in || (is_bal && off_hook_in));
   wire logic seq_end   = cal_state == CAL_PICK && pending == 16'h0000;

   wire logic [W-1:0] tip_abs_diff = tip_voltage_in > ring_voltage_in
                                     ? W'(tip_voltage_in - ring_voltage_in)
                                     : W'(ring_voltage_in - tip_voltage_in);
   wire logic samp_tick = samp_cnt == SAMP_W'(SAMPLE_CYCLES - 1);

   logic [5:0] cmp_now;
   always_comb begin
      for (int k = 0; k < 6; k++) begin
         cmp_now[k] = {4'h0, q_pow[k*2*W +: 2*W]} > (2*W+4)'(pth);
      end
   end
   // First-order thermal approximation by shift-and-add
   wire logic [PW-1:0] next_filt = filt_pow - (filt_pow >> linefeed_pkg::DEFAULT_FILTER_SHIFT)
                                   + (total_pow >> linefeed_pkg::DEFAULT_FILTER_SHIFT);
   wire logic total_over = linefeed_presence_pin_in && PW'(pth) < filt_pow;
   // Alarms only act on the sample tick so the edge detect sees stable samples
   wire logic [5:0] alarm_set = !samp_tick ? 6'h00
                              : linefeed_presence_pin_in
                                ? {5'h00, total_over && !total_prev} // RULE_23
                                : (cmp_now & ~cmp_prev); // RULE_20
   wire logic any_alarm = |alarm_set;

   // Calibration sequencer
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cal_state   <= CAL_IDLE;
         cal_primary <= linefeed_pkg::RESET_BYTE;
         pending     <= 16'h0000;
         cur_idx     <= 4'h0;
         step_cnt    <= '0;
      end else if (clk_en_in) begin
         unique case (cal_state)
            CAL_IDLE: begin
               if (start) begin
                  cal_primary <= reg_wdata_in & 8'hbf;
                  pending     <= select_vec;
                  cal_state   <= CAL_PICK;
               end else if (wr_pri) begin
                  cal_primary <= reg_wdata_in & 8'hbf;
               end
            end
            CAL_PICK: begin
               if (seq_end) begin
                  cal_primary <= linefeed_pkg::RESET_BYTE; // RULE_01 RULE_13
                  cal_state   <= CAL_IDLE;
               end else begin
                  cur_idx   <= top_bit(pending); // RULE_03
                  step_cnt  <= '0;
                  cal_state <= CAL_RUN;
               end
            end
            CAL_RUN: begin
               step_cnt <= LEAK_W'(step_cnt + 1'b1);
               if (step_done || step_err) begin
                  pending[cur_idx] <= 1'b0;
                  cal_state        <= CAL_PICK;
               end
            end
         endcase
      end
   end

   // Register file, monitor and alarms
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cal_secondary <= linefeed_pkg::RESET_BYTE;
         coef_a        <= linefeed_pkg::RESET_BYTE;
         coef_b        <= linefeed_pkg::RESET_BYTE;
         irq_status    <= linefeed_pkg::RESET_BYTE;
         irq_enable    <= linefeed_pkg::RESET_BYTE;
         line_state    <= linefeed_pkg::STATE_OPEN; // RULE_02
         samp_cnt      <= '0;
         loop_v        <= '0;
         loop_i        <= '0;
         cmp_prev      <= 6'h00;
         filt_pow      <= '0;
         total_prev    <= 1'b0;
         total_power_value          <= 16'h0000;
         pth           <= linefeed_pkg::PTH_RESET;
      end else if (clk_en_in) begin
         if (wr_sec) cal_secondary <= reg_wdata_in;
         if (wr_ca) coef_a <= reg_wdata_in;
         if (wr_cb) coef_b <= reg_wdata_in;
         if (wr_en3) irq_enable <= reg_wdata_in;
         if (wr_pl) pth[7:0] <= reg_wdata_in;
         if (wr_ph) pth[15:8] <= reg_wdata_in;
         // Write-one-to-clear; a hardware set in the same cycle wins
         irq_status <= (irq_status & ~(wr_st3 ? reg_wdata_in : 8'h00))
                       | {step_err, 1'b0, alarm_set}; // RULE_07 RULE_20
         // Alarm forces open regardless of the enable mask
         if (any_alarm) line_state <= linefeed_pkg::STATE_OPEN; // RULE_18 RULE_24
         else if (wr_state) line_state <= reg_wdata_in[2:0];
         samp_cnt <= samp_tick ? '0 : SAMP_W'(samp_cnt + 1'b1);
         if (samp_tick) begin // RULE_16
            loop_v     <= ground_start_in ? ring_voltage_in : tip_abs_diff; // RULE_17
            loop_i     <= ground_start_in ? ring_current_in : tip_current_in; // RULE_17
            cmp_prev   <= cmp_now;
            filt_pow   <= next_filt;
            total_prev <= total_over;
            // Unfiltered sum, saturated so an overflow never reads as a small power
            total_power_value       <= total_pow > PW'(16'hffff) ? 16'hffff : total_pow[15:0]; // RULE_22
         end
      end
   end

   wire logic [7:0] rdata =
      reg_addr_in == linefeed_pkg::ADDR_CAL_PRI    ? cal_primary :
      reg_addr_in == linefeed_pkg::ADDR_CAL_SEC    ? cal_secondary :
      reg_addr_in == linefeed_pkg::ADDR_IRQ_ST3    ? (irq_status & irq_enable) : // RULE_21
      reg_addr_in == linefeed_pkg::ADDR_IRQ_EN3    ? irq_enable :
      reg_addr_in == linefeed_pkg::ADDR_LINE_STATE ? {5'h00, line_state} :
      reg_addr_in == linefeed_pkg::ADDR_COEF_A     ? coef_a :
      reg_addr_in == linefeed_pkg::ADDR_COEF_B     ? coef_b :
      reg_addr_in == linefeed_pkg::ADDR_LOOP_V     ? 8'(loop_v) :
      reg_addr_in == linefeed_pkg::ADDR_LOOP_I     ? 8'(loop_i) :
      reg_addr_in == linefeed_pkg::ADDR_TOTAL_POWER_VALUE_LO    ? total_power_value[7:0] :
      reg_addr_in == linefeed_pkg::ADDR_TOTAL_POWER_VALUE_HI    ? total_power_value[15:8] :
      reg_addr_in == linefeed_pkg::ADDR_PTH_LO     ? pth[7:0] :
      reg_addr_in == linefeed_pkg::ADDR_PTH_HI     ? pth[15:8] : 8'h00;

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) reg_rdata_out <= 8'h00;
      else if (clk_en_in && reg_rd_in) reg_rdata_out <= rdata;
   end

   assign cal_drive_out  = cal_state != CAL_IDLE; // RULE_08
   assign cal_step_out   = cal_state == CAL_RUN ? 8'(8'h01 << cur_idx[2:0]) : 8'h00;
   assign leak_busy_out  = cal_state == CAL_RUN && is_leak; // RULE_10
   assign line_state_out = line_state;

   chk_start_clears: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      clk_en_in && seq_end |=> cal_primary == 8'h00 && !cal_drive_out) // RULE_01
      else $error("primary register not cleared at sequence end");
   chk_open_after_alarm: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      clk_en_in && any_alarm |=> line_state_out == linefeed_pkg::STATE_OPEN) // RULE_18
      else $error("line not opened after power alarm");
   chk_alarm_sticky: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      clk_en_in && irq_status[0] && !wr_st3 |=> irq_status[0]) // RULE_20
      else $error("alarm bit dropped without clear");
   chk_cal_error_flag: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      clk_en_in && step_err |=> irq_status[linefeed_pkg::CAL_ERR_BIT]) // RULE_07
      else $error("calibration error not flagged");
   chk_drive_during_cal: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      cal_state == CAL_RUN |-> cal_drive_out && $onehot(cal_step_out)) // RULE_08
      else $error("drive not owned during calibration");
   chk_order_msb: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      clk_en_in && cal_state == CAL_PICK && !seq_end |=> pending[cur_idx]
      && (pending >> cur_idx) == 16'h0001) // RULE_03
      else $error("calibration step not highest pending");
   chk_mask_reads: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      clk_en_in && reg_rd_in && reg_addr_in == linefeed_pkg::ADDR_IRQ_ST3
      |=> reg_rdata_out == $past(irq_status & irq_enable)) // RULE_21
      else $error("masked status read mismatch");
   chk_ground_start: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      clk_en_in && samp_tick && ground_start_in |=> loop_v == $past(ring_voltage_in)) // RULE_17
      else $error("ground start does not report ring voltage");
endmodule : linefeed_channel

// ===== bench/host_model.sv
`timescale 1ns/10ps
module host_model (
   input  wire logic       clk_in,
   input  wire logic [7:0] rdata_in,
   output logic            wr_out,
   output logic            rd_out,
   output logic [7:0]      addr_out,
   output logic [7:0]      wdata_out
);
   initial begin
      wr_out = 1'b0;
      rd_out = 1'b0;
      addr_out = 8'h00;
      wdata_out = 8'h00;
   end
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      logic [7:0] d;
      d = data;
      if (addr == linefeed_pkg::ADDR_CAL_PRI) begin
         d[linefeed_pkg::CAL_RSVD_BIT] = 1'b0;
      end
      @(posedge clk_in);
      wr_out <= 1'b1;
      addr_out <= addr;
      wdata_out <= d;
      @(posedge clk_in);
      wr_out <= 1'b0;
      // Released lines show a changed pattern so stale values are never trusted
      addr_out <= ~addr;
      wdata_out <= ~d;
   endtask : write_reg
   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
      @(posedge clk_in);
      rd_out <= 1'b1;
      addr_out <= addr;
      @(posedge clk_in);
      rd_out <= 1'b0;
      addr_out <= ~addr;
      @(negedge clk_in);
      data = rdata_in;
   endtask : read_reg
   // Selections always land before the start write
   task automatic cal_start(input logic [7:0] sec, input logic [7:0] pri);
      write_reg(linefeed_pkg::ADDR_CAL_SEC, sec);
      write_reg(linefeed_pkg::ADDR_CAL_PRI, pri);
   endtask : cal_start
endmodule : host_model

// ===== bench/testbench.sv
`timescale 1ns/10ps
module testbench;
   localparam int LEAK = 50;
   localparam int SAMP = 10;
   logic        core_clk_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic        wr, rd, gnd_start = 1'b0, presence = 1'b0, off_hook = 1'b0;
   logic [7:0]  addr, wdata, rdata, rv, tip_v = 8'h00, ring_v = 8'h00;
   logic [7:0]  tip_i = 8'h00, ring_i = 8'h00, bat_v = 8'h3c;
   logic [47:0] q_i = 48'h0;
   logic        cal_drive, leak_busy;
   logic        clk_en = 1'b1, cal_fail = 1'b0;
   logic [7:0]  cal_step;
   logic [2:0]  line_state;
   int          n_mismatch = 0;
   int          n_checks = 0;
   always #5 core_clk_in = ~core_clk_in;
   linefeed_channel #(.W(8), .LEAK_CYCLES(LEAK), .STEP_CYCLES(20), .SAMPLE_CYCLES(SAMP)) dut (
      .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_rdata_out(rdata), .tip_voltage_in(tip_v), .ring_voltage_in(ring_v),
      .bat_voltage_in(bat_v), .tip_current_in(tip_i), .ring_current_in(ring_i),
      .q_current_in(q_i), .drop_r7_in(8'h01), .drop_r6_in(8'h01),
      .ground_start_in(gnd_start), .linefeed_presence_pin_in(presence),
      .off_hook_in(off_hook), .cal_step_fail_in(cal_fail), .cal_drive_out(cal_drive),
      .cal_step_out(cal_step), .leak_busy_out(leak_busy), .line_state_out(line_state));
   host_model host (.clk_in(core_clk_in), .rdata_in(rdata), .wr_out(wr), .rd_out(rd),
      .addr_out(addr), .wdata_out(wdata));
   task automatic finish_test();
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
      n_checks++;
      if (got !== exp) begin
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
         n_mismatch++;
      end
   endtask : check
   task automatic rd_check(input logic [7:0] a, input logic [7:0] exp, input string msg);
      host.read_reg(a, rv);
      check(rv, exp, msg);
   endtask : rd_check
   // Polls with a bound so a stuck sequencer ends the run instead of hanging it
   task automatic wait_cal();
      for (int i = 0; i < 200; i++) begin
         host.read_reg(linefeed_pkg::ADDR_CAL_PRI, rv);
         if (rv === 8'h00) return;
      end
      $display("[FAIL] %0t calibration never finished", $time);
      n_mismatch++;
      finish_test();
   endtask : wait_cal
   task automatic t_reset();
      check({5'h00, line_state}, {5'h00, linefeed_pkg::STATE_OPEN}, "open after reset");
      check({7'h00, cal_drive}, 8'h00, "idle drive after reset");
      rd_check(linefeed_pkg::ADDR_CAL_PRI, 8'h00, "primary reset");
      rd_check(linefeed_pkg::ADDR_PTH_LO, 8'hff, "threshold low reset");
      rd_check(linefeed_pkg::ADDR_PTH_HI, 8'hff, "threshold high reset");
      rd_check(8'hff, 8'h00, "unmapped read");
   endtask : t_reset
   task automatic t_balance();
      host.write_reg(linefeed_pkg::ADDR_COEF_A, 8'h05);
      host.write_reg(linefeed_pkg::ADDR_COEF_B, 8'h01);
      rd_check(linefeed_pkg::ADDR_COEF_A, 8'h05, "coef a readback");
      host.write_reg(linefeed_pkg::ADDR_IRQ_EN3, 8'h80);
      host.cal_start(8'h01, 8'h80);
      repeat (2) @(posedge core_clk_in);
      #1 check({7'h00, cal_drive}, 8'h01, "drive owned in cal");
      wait_cal();
      check({7'h00, cal_drive}, 8'h00, "drive released");
      rd_check(linefeed_pkg::ADDR_IRQ_ST3, 8'h00, "no cal error");
   endtask : t_balance
   task automatic t_leak();
      int cnt;
      cnt = 0;
      host.cal_start(8'h00, 8'hb0);
      for (int i = 0; i < 400; i++) begin
         @(posedge core_clk_in);
         #1 if (leak_busy === 1'b1) cnt++;
         if (i > 5 && cal_drive === 1'b0) break;
      end
      n_checks++;
      if (cnt < 2 * LEAK || cnt > 2 * LEAK + 10) begin
         $display("[FAIL] %0t leakage busy %0d cycles", $time, cnt);
         n_mismatch++;
      end
      rd_check(linefeed_pkg::ADDR_CAL_PRI, 8'h00, "start bit self clears");
   endtask : t_leak
   task automatic t_offhook();
      host.cal_start(8'h01, 8'h80);
      repeat (4) @(posedge core_clk_in);
      off_hook <= 1'b1;
      wait_cal();
      @(posedge core_clk_in);
      off_hook <= 1'b0;
      rd_check(linefeed_pkg::ADDR_IRQ_ST3, 8'h80, "off-hook cal error");
      host.write_reg(linefeed_pkg::ADDR_IRQ_ST3, 8'h80);
      rd_check(linefeed_pkg::ADDR_IRQ_ST3, 8'h00, "cal error cleared");
   endtask : t_offhook
   task automatic t_monitor();
      @(posedge core_clk_in);
      tip_v <= 8'd50;
      ring_v <= 8'd20;
      tip_i <= 8'd12;
      ring_i <= 8'd12;
      repeat (3 * SAMP) @(posedge core_clk_in);
      rd_check(linefeed_pkg::ADDR_LOOP_V, 8'd30, "loop voltage");
      rd_check(linefeed_pkg::ADDR_LOOP_I, 8'd12, "loop current");
      gnd_start <= 1'b1;
      ring_i <= 8'd9;
      repeat (3 * SAMP) @(posedge core_clk_in);
      rd_check(linefeed_pkg::ADDR_LOOP_V, 8'd20, "ring voltage");
      rd_check(linefeed_pkg::ADDR_LOOP_I, 8'd9, "ring current");
      @(posedge core_clk_in);
      gnd_start <= 1'b0;
   endtask : t_monitor
   task automatic t_power();
      @(posedge core_clk_in);
      q_i <= 48'h2;
      presence <= 1'b1;
      repeat (3 * SAMP) @(posedge core_clk_in);
      // Only Q1 conducts: (50 + 3) * 2
      rd_check(linefeed_pkg::ADDR_TOTAL_POWER_VALUE_LO, 8'h6a, "total power low");
      rd_check(linefeed_pkg::ADDR_TOTAL_POWER_VALUE_HI, 8'h00, "total power high");
      @(posedge core_clk_in);
      presence <= 1'b0;
      host.write_reg(linefeed_pkg::ADDR_IRQ_EN3, 8'h00);
      host.write_reg(linefeed_pkg::ADDR_LINE_STATE, 8'h01);
      @(negedge core_clk_in);
      check({5'h00, line_state}, 8'h01, "state leaves open");
      host.write_reg(linefeed_pkg::ADDR_PTH_LO, 8'h00);
      host.write_reg(linefeed_pkg::ADDR_PTH_HI, 8'h00);
      repeat (30 * SAMP) @(posedge core_clk_in);
      #1 check({5'h00, line_state}, {5'h00, linefeed_pkg::STATE_OPEN}, "alarm opens");
      rd_check(linefeed_pkg::ADDR_IRQ_ST3, 8'h00, "masked alarm hidden");
      check({5'h00, line_state}, {5'h00, linefeed_pkg::STATE_OPEN}, "stays open");
      host.write_reg(linefeed_pkg::ADDR_IRQ_EN3, 8'h3f);
      rd_check(linefeed_pkg::ADDR_IRQ_ST3, 8'h01, "q1 alarm only");
      host.write_reg(linefeed_pkg::ADDR_IRQ_ST3, 8'h01);
      rd_check(linefeed_pkg::ADDR_IRQ_ST3, 8'h00, "alarm held until edge");
   endtask : t_power
   task automatic t_fail_freeze();
      host.write_reg(linefeed_pkg::ADDR_IRQ_EN3, 8'h80);
      host.cal_start(8'h00, 8'h88);
      repeat (3) @(posedge core_clk_in);
      #1 check(cal_step, 8'h08, "primary bit 3 step running");
      @(posedge core_clk_in);
      cal_fail <= 1'b1;
      @(posedge core_clk_in);
      cal_fail <= 1'b0;
      wait_cal();
      rd_check(linefeed_pkg::ADDR_IRQ_ST3, 8'h80, "step failure flagged");
      // Enable low must hold even the write-one-to-clear flags
      @(posedge core_clk_in);
      clk_en <= 1'b0;
      host.write_reg(linefeed_pkg::ADDR_IRQ_ST3, 8'h80);
      @(posedge core_clk_in);
      clk_en <= 1'b1;
      rd_check(linefeed_pkg::ADDR_IRQ_ST3, 8'h80, "write ignored while frozen");
      host.write_reg(linefeed_pkg::ADDR_IRQ_ST3, 8'h80);
      rd_check(linefeed_pkg::ADDR_IRQ_ST3, 8'h00, "write taken after thaw");
   endtask : t_fail_freeze
   initial begin
      repeat (20000) @(posedge core_clk_in);
      $display("[FAIL] %0t run timed out", $time);
      n_mismatch++;
      finish_test();
   end
   initial begin
      repeat (8) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      @(negedge core_clk_in);
      t_reset();
      t_balance();
      t_leak();
      t_offhook();
      t_monitor();
      t_power();
      t_fail_freeze();
      finish_test();
   end
endmodule : testbench
